// File: rtl/eeb_pkg.sv
// Constants shared by the serial EEPROM bus slave front end.
// Assumes a 10 MHz system clock; all bus pins are asynchronous to it.
package eeb_pkg;
    // ==========================================
    // Clock and timing
    localparam int SYS_CLK_HZ        = 10_000_000;
    localparam int GLITCH_NS         = 50;
    localparam int GLITCH_CYC_RAW    = (GLITCH_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    // Pulse at or below the limit is swallowed: need strictly longer, at least one cycle
    localparam int GLITCH_CYC        = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
    localparam int POWER_UP_DELAY_US = 100;   // 0.1 ms
    localparam int POWER_UP_CYC      = POWER_UP_DELAY_US * (SYS_CLK_HZ / 1_000_000);
    localparam int WRITE_CYCLE_US    = 5000;  // 5 ms
    localparam int WRITE_CYC         = WRITE_CYCLE_US * (SYS_CLK_HZ / 1_000_000);
    // ==========================================
    // Slave address byte layout
    localparam int        TYPE_MSB  = 7;
    localparam int        TYPE_LSB  = 4;
    localparam int        SEL_MSB   = 3;
    localparam int        SEL_LSB   = 2;
    localparam int        PAGE_BIT  = 1;
    localparam int        RW_BIT    = 0;
    localparam int        BYTE_BITS = 8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    // Arbitrary neutral value: device-type code
    localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
    // ==========================================
    // Protocol states
    typedef enum logic [5:0] {
        EEB_IDLE = 6'h01,
        EEB_RX   = 6'h02,
        EEB_ACK  = 6'h04,
        EEB_TX   = 6'h08,
        EEB_MACK = 6'h10,
        EEB_SKIP = 6'h20
    } eeb_state_e;
endpackage : eeb_pkg

// File: rtl/eeb_pin_filter.sv
// Pin synchroniser plus glitch filter for one bus input.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module eeb_pin_filter #(
    parameter int    HOLD_CYC = 1,
    parameter logic  IDLE_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Pin in, filtered level out
    input  wire logic pin,
    output logic      level
);
    logic       sync_a;
    logic       sync_b;
    logic [7:0] run;
    logic [7:0] next_run;
    logic       next_level;

    // ==========================================
    // Level accepted only after it outlasts the glitch limit
    always_comb begin
        next_run   = 8'h00;
        next_level = level;
        if (sync_b != level) begin
            next_run = run + 8'h01;
            if (next_run > 8'(HOLD_CYC)) begin  // see R1
                next_level = sync_b;
                next_run   = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_a <= IDLE_VAL;
            sync_b <= IDLE_VAL;
            run    <= 8'h00;
            level  <= IDLE_VAL;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            run    <= next_run;
            level  <= next_level;
        end
    end

    a_glitch_block: assert property (@(posedge clk_sys) disable iff (reset)  // see R1
        $changed(level) |-> ($past(sync_b) == level) && ($past(sync_b, 2) == level))
        else $error("level moved on a short pulse");
endmodule : eeb_pin_filter

// File: rtl/eeb_slave.sv
// Two-wire bus slave front end of a serial EEPROM.
// Assumes reset comes from the supply monitor; bus pins are asynchronous.
`timescale 1ns/1ps

// How it works
// R1: Pulses on clock or data no longer than 50 ns are filtered out.
// R2: After reset release the device accepts commands within 0.1 ms.
// R3: Leaving supply reset puts the device in standby awaiting START.
// R4: Supply reset at any time returns all logic to its reset state.
// R5: Data line is only pulled low or released, never driven high.
// R6: Incoming data bits are sampled on the serial clock rising edge.
// R7: Outgoing data changes only after a serial clock falling edge.
// R8: Write-protect high refuses every write operation.
// R9: Undriven write-protect reads low, so writes are allowed.
// R10: Undriven select straps read as zero for address matching.
// R11: The master makes the clock and all START and STOP conditions.
// R12: Device answers only to its own two-bit strap value, four per bus.
// R13: Address byte is type code, two strap bits, page bit, read flag.
// R14: Matching address, address bytes and written data are acked low.
// R15: STOP after write starts the write cycle; after read, standby.
// R16: While writing internally, the slave address is not acknowledged.
// R17: Internal write finishes within the write-cycle time, then acks again.
// R18: The master keeps its clock within the chosen speed grade limit.
module eeb_slave import eeb_pkg::*; #(
    parameter int         WRITE_CYCLES = WRITE_CYC,
    parameter logic [3:0] TYPE_CODE    = TYPE_CODE_DEF
) (
    // Clock and supply reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Straps and protect (pulled down outside, pin-level inputs)
    input  wire logic select_strap_low,
    input  wire logic select_strap_high,
    input  wire logic write_protect,
    // Status and data toward the array side
    input  wire logic [7:0] read_data,
    output logic            ready,
    output logic            write_busy,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            page_address_msb
);
    logic       scl;
    logic       sda;
    logic       scl_d;
    logic       sda_d;
    logic [1:0] sel_s1, sel_s2;
    logic [1:0] wp_s;
    eeb_state_e state, next_state;
    logic [3:0] bitn, next_bitn;
    logic [7:0] shreg, next_shreg;
    logic [1:0] bytes, next_bytes;
    logic       is_read, next_is_read;
    logic       wr_pend, next_wr_pend;
    logic       next_sda_oe;
    logic       next_rx_valid;
    logic [7:0] next_rx_data;
    logic       next_page_msb;
    logic [31:0] wcnt, next_wcnt;
    logic [31:0] pcnt, next_pcnt;
    logic       next_ready;
    logic       next_busy;
    logic       rise, fall, start_c, stop_c;

    // ==========================================
    // Input conditioning
    eeb_pin_filter #(.HOLD_CYC(GLITCH_CYC), .IDLE_VAL(1'b1)) u_scl (
        .clk_sys(clk_sys), .reset(reset), .pin(scl_in), .level(scl));  // see R1
    eeb_pin_filter #(.HOLD_CYC(GLITCH_CYC), .IDLE_VAL(1'b1)) u_sda (
        .clk_sys(clk_sys), .reset(reset), .pin(sda_in), .level(sda));  // see R1

    assign rise    = scl & ~scl_d;
    assign fall    = ~scl & scl_d;
    assign start_c = scl & scl_d & sda_d & ~sda;  // see R11
    assign stop_c  = scl & scl_d & ~sda_d & sda;  // see R11

    function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] sel);
        addr_hit = (b[TYPE_MSB:TYPE_LSB] == TYPE_CODE) && (b[SEL_MSB:SEL_LSB] == sel);  // see R13
    endfunction : addr_hit

    // ==========================================
    // Protocol engine
    always_comb begin
        next_state    = state;
        next_bitn     = bitn;
        next_shreg    = shreg;
        next_bytes    = bytes;
        next_is_read  = is_read;
        next_wr_pend  = wr_pend;
        next_sda_oe   = sda_oe;
        next_rx_valid = 1'b0;
        next_rx_data  = rx_data;
        next_page_msb = page_address_msb;
        next_wcnt     = wcnt;
        next_pcnt     = pcnt;
        next_ready    = ready;
        next_busy     = write_busy;
        if (!ready) begin
            next_pcnt = pcnt + 32'h1;
            if (next_pcnt >= 32'(POWER_UP_CYC)) begin
                next_ready = 1'b1;  // see R2
            end
        end
        if (write_busy) begin
            next_wcnt = wcnt + 32'h1;
            if (next_wcnt >= 32'(WRITE_CYCLES)) begin
                next_busy = 1'b0;  // see R17
                next_wcnt = 32'h0;
            end
        end
        if (!ready) begin
            next_state = EEB_IDLE;  // see R3
        end else if (stop_c) begin
            next_state  = EEB_IDLE;
            next_sda_oe = 1'b0;
            if (wr_pend && !write_busy) begin
                next_busy = 1'b1;  // see R15
            end
            next_wr_pend = 1'b0;
        end else if (start_c) begin
            next_state  = EEB_RX;
            next_bitn   = 4'h0;
            next_bytes  = 2'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                EEB_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                EEB_RX: begin
                    if (rise) begin
                        next_shreg = {shreg[6:0], sda};  // see R6
                        next_bitn  = bitn + 4'h1;
                    end else if (fall && bitn == BIT_ACK) begin
                        next_bitn = 4'h0;
                        if (bytes == 2'h0) begin
                            if (addr_hit(shreg, sel_s2) && !write_busy) begin  // see R12 R16
                                next_sda_oe   = 1'b1;  // see R14
                                next_is_read  = shreg[RW_BIT];
                                next_page_msb = shreg[PAGE_BIT];
                                next_state    = EEB_ACK;
                            end else begin
                                next_state = EEB_IDLE;
                            end
                        end else if (bytes == 2'h3 && wp_s[1]) begin
                            next_state   = EEB_SKIP;  // see R8
                            next_wr_pend = 1'b0;
                        end else begin
                            next_sda_oe   = 1'b1;  // see R14
                            next_rx_valid = 1'b1;
                            next_rx_data  = shreg;
                            if (bytes == 2'h3) begin
                                next_wr_pend = 1'b1;
                            end
                            next_state = EEB_ACK;
                        end
                        if (bytes != 2'h3) begin
                            next_bytes = bytes + 2'h1;
                        end
                    end
                end
                EEB_ACK: begin
                    if (fall) begin
                        next_sda_oe = 1'b0;  // see R7
                        if (is_read) begin
                            next_shreg  = read_data;
                            next_sda_oe = ~read_data[BYTE_BITS - 1];
                            next_bitn   = 4'h1;
                            next_state  = EEB_TX;
                        end else begin
                            next_state = EEB_RX;
                        end
                    end
                end
                EEB_TX: begin
                    if (fall) begin
                        if (bitn == BIT_ACK) begin
                            next_sda_oe = 1'b0;
                            next_state  = EEB_MACK;
                        end else begin
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];  // see R5 R7
                            next_bitn   = bitn + 4'h1;
                        end
                    end
                end
                EEB_MACK: begin
                    if (rise) begin
                        next_state = sda ? EEB_IDLE : EEB_ACK;
                    end
                end
                EEB_SKIP: begin
                    next_sda_oe = 1'b0;
                end
                default: next_state = EEB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin  // see R4
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            sel_s1 <= 2'h0;  // see R10
            sel_s2 <= 2'h0;
            wp_s <= 2'h0;  // see R9
            state <= EEB_IDLE;
            bitn <= 4'h0;
            shreg <= 8'h00;
            bytes <= 2'h0;
            is_read <= 1'b0;
            wr_pend <= 1'b0;
            sda_oe <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            page_address_msb <= 1'b0;
            wcnt <= 32'h0;
            pcnt <= 32'h0;
            ready <= 1'b0;
            write_busy <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            sel_s1 <= {select_strap_high, select_strap_low};
            sel_s2 <= sel_s1;
            wp_s <= {wp_s[0], write_protect};
            state <= next_state;
            bitn <= next_bitn;
            shreg <= next_shreg;
            bytes <= next_bytes;
            is_read <= next_is_read;
            wr_pend <= next_wr_pend;
            sda_oe <= next_sda_oe;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            page_address_msb <= next_page_msb;
            wcnt <= next_wcnt;
            pcnt <= next_pcnt;
            ready <= next_ready;
            write_busy <= next_busy;
        end
    end

    // Open drain: the driven value is always low
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;  // see R5
        end
    end

    // ==========================================
    // Checks
    a_never_high: assert property (@(posedge clk_sys) disable iff (reset)
        !(sda_oe && sda_out)) else $error("data line driven high");  // see R5
    a_oe_on_fall: assert property (@(posedge clk_sys) disable iff (reset)  // see R7
        $changed(sda_oe) && !$past(stop_c) && !$past(start_c) |-> $past(fall))
        else $error("data changed off falling edge");
    a_busy_no_ack: assert property (@(posedge clk_sys) disable iff (reset)  // see R16
        write_busy && state == EEB_RX && bytes == 2'h0 |=> !(state == EEB_ACK))
        else $error("address acked while busy");
    a_stop_writes: assert property (@(posedge clk_sys) disable iff (reset)  // see R15
        stop_c && wr_pend && !write_busy && ready |=> write_busy)
        else $error("stop did not start write");
    a_wp_refuse: assert property (@(posedge clk_sys) disable iff (reset)
        state == EEB_SKIP |-> !sda_oe && !wr_pend) else $error("protected write accepted");  // see R8
    a_power_ready: assert property (@(posedge clk_sys) disable iff (reset)
        !ready |-> pcnt < 32'(POWER_UP_CYC)) else $error("power-up too slow");  // see R2
    a_write_ends: assert property (@(posedge clk_sys) disable iff (reset)
        write_busy |-> wcnt < 32'(WRITE_CYCLES)) else $error("write cycle overrun");  // see R17
    a_idle_unready: assert property (@(posedge clk_sys) disable iff (reset)
        !ready |=> state == EEB_IDLE) else $error("active before ready");  // see R3
    a_rx_sample: assert property (@(posedge clk_sys) disable iff (reset)  // see R6
        state == EEB_RX && rise && !start_c && !stop_c |=> shreg[0] == $past(sda))
        else $error("bit not captured on rise");
endmodule : eeb_slave

// File: bench/eeb_master_model.sv
// Bus master model: paces the serial clock from clk_sys, makes START/STOP.
// Assumes the data wire is resolved outside with a pull-up.
`timescale 1ns/1ps
module eeb_master_model (
    // Pacing clock
    input  wire logic clk_sys,
    // Bus
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    // ==========================================
    // Bit engine
    logic glitch = 1'h0;
    int   slow   = 0;
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : w
    task automatic bit_io(input logic b, output logic seen);
        w(6 + slow);
        sda_low = ~b;
        w(2);
        scl = 1'h1;
        if (glitch) begin
            #150;
            scl = 1'h0;
            sda_low = 1'h1;
            #50;
            scl = 1'h1;
            sda_low = ~b;
        end
        w(4);
        seen = sda_line;
        scl = 1'h0;
    endtask : bit_io
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) bit_io(d[i], x);
        bit_io(1'h1, x);
        ack = ~x;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    endtask : recv_byte
    // ==========================================
    // Frame edges
    task automatic start();
        w(6);
        sda_low = 1'h0;
        w(2);
        scl = 1'h1;
        w(4);
        sda_low = 1'h1;
        w(4);
        scl = 1'h0;
    endtask : start
    task automatic stop();
        w(6);
        sda_low = 1'h1;
        w(2);
        scl = 1'h1;
        w(4);
        sda_low = 1'h0;
        w(4);
    endtask : stop
endmodule : eeb_master_model

// File: bench/serial_eeprom_bus_slave_tb_top.sv
// Self-checking bench for the EEPROM bus slave front end.
// Assumes the master model paces the bus; straps and protect pulled down.
`timescale 1ns/1ps
module serial_eeprom_bus_slave_tb_top;
    import eeb_pkg::*;
    // ==========================================
    // Signals
    localparam int WR_CYC = 400;
    logic       clk_sys;
    logic       reset;
    logic       scl;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe;
    wire logic  sda_line = ~sda_low & (sda_oe ? sda_out : 1'h1);
    tri0        strap_low_pin;
    tri0        strap_high_pin;
    tri0        wp_pin;
    logic [1:0] strap_val;
    logic       strap_en;
    logic       wp_en;
    logic [7:0] read_data;
    logic       ready;
    logic       write_busy;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       page_msb;
    logic [7:0] last_rx = 8'h00;
    logic       ack;
    logic [7:0] b;
    int         num_errors = 0;
    int         checks = 0;
    int         cyc = 0;
    assign strap_low_pin  = strap_en ? strap_val[0] : 1'hZ;
    assign strap_high_pin = strap_en ? strap_val[1] : 1'hZ;
    assign wp_pin = wp_en ? 1'h1 : 1'hZ;
    eeb_slave #(.WRITE_CYCLES(WR_CYC)) uut (
        .clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_strap_low(strap_low_pin),
        .select_strap_high(strap_high_pin), .write_protect(wp_pin),
        .read_data(read_data), .ready(ready), .write_busy(write_busy),
        .rx_valid(rx_valid), .rx_data(rx_data), .page_address_msb(page_msb));
    eeb_master_model m (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ==========================================
    // Monitors and helpers
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rx_valid === 1'h1) last_rx <= rx_data;
        if (sda_oe === 1'h1 && sda_out !== 1'h0) fail("sda_out", 8'h00, 8'h01);
    end
    always @(sda_oe) if (reset === 1'h0 && scl !== 1'h0) fail("oe edge", 8'h00, 8'h01);
    task automatic fail(input string n, input logic [7:0] e, input logic [7:0] g);
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
    endtask : fail
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) fail(n, e, g);
    endtask : chk
    function automatic logic [7:0] adr(input logic [1:0] s, input logic p, input logic r);
        return {TYPE_CODE_DEF, s, p, r};
    endfunction : adr
    task automatic sel(input logic [7:0] a, input logic e, input string n);
        m.start();
        m.send_byte(a, ack);
        chk(n, 8'(e), 8'(ack));
    endtask : sel
    task automatic data(input logic [7:0] d, input logic e);
        m.send_byte(d, ack);
        chk("data ack", 8'(e), 8'(ack));
    endtask : data
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================
    // Scenarios
    task automatic t_power();
        int n;
        chk("busy at reset", 8'h00, 8'(write_busy));
        for (n = 0; n < 1100 && ready !== 1'h1; n++) m.w(1);
        chk("ready bound", 8'h01, 8'(ready === 1'h1 && n <= POWER_UP_CYC + 4));
        m.w(1);
        $display("power up done");
    endtask : t_power
    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            strap_val = 2'(s);
            strap_en = (s != 0);
            m.w(4);
            for (int t = 0; t < 4; t++) begin
                sel(adr(2'(t), t[0], 1'h0), t == s, "address ack");
                if (t == s) chk("page bit", 8'(t[0]), 8'(page_msb));
                if (t == s) data(8'h80 | 8'(t), 1'h1);
                if (t == s) chk("rx address", 8'h80 | 8'(t), last_rx);
                m.stop();
            end
        end
        sel({TYPE_CODE_DEF ^ 4'h3, 4'hC}, 1'h0, "wrong type");
        m.stop();
        $display("select done");
    endtask : t_select
    task automatic t_write();
        int t0;
        sel(adr(2'h3, 1'h1, 1'h0), 1'h1, "write address");
        data(8'h12, 1'h1);
        data(8'h34, 1'h1);
        data(8'hC3, 1'h1);
        chk("rx data", 8'hC3, last_rx);
        m.stop();
        t0 = cyc;
        m.w(6);
        chk("busy after stop", 8'h01, 8'(write_busy));
        sel(adr(2'h3, 1'h0, 1'h1), 1'h0, "poll busy");
        m.stop();
        while (write_busy === 1'h1 && cyc - t0 < WR_CYC + 40) m.w(1);
        chk("write time", 8'h01, 8'(cyc - t0 <= WR_CYC + 20));
        sel(adr(2'h3, 1'h0, 1'h1), 1'h1, "ack after write");
        m.recv_byte(b);
        chk("poll read", 8'h00, b);
        m.bit_io(1'h1, ack);
        m.stop();
        wp_en = 1'h1;
        m.w(4);
        sel(adr(2'h3, 1'h0, 1'h0), 1'h1, "protected address");
        data(8'h00, 1'h1);
        data(8'h10, 1'h1);
        data(8'h77, 1'h0);
        m.stop();
        m.w(6);
        chk("no write", 8'h00, 8'(write_busy));
        wp_en = 1'h0;
        $display("write done");
    endtask : t_write
    task automatic t_read();
        read_data = 8'hA5;
        m.slow = 2;
        sel(adr(2'h3, 1'h0, 1'h1), 1'h1, "read address");
        m.recv_byte(b);
        chk("read byte 1", 8'hA5, b);
        read_data = 8'h3C;
        m.bit_io(1'h0, ack);
        m.recv_byte(b);
        chk("read byte 2", 8'h3C, b);
        m.bit_io(1'h1, ack);
        m.stop();
        m.slow = 0;
        m.w(6);
        chk("standby", 8'h00, 8'(write_busy | sda_oe));
        m.glitch = 1'h1;
        sel(adr(2'h3, 1'h1, 1'h0), 1'h1, "glitch address");
        data(8'h5A, 1'h1);
        chk("glitch byte", 8'h5A, last_rx);
        m.stop();
        m.glitch = 1'h0;
        $display("read and glitch done");
    endtask : t_read
    task automatic t_brown();
        read_data = 8'h00;
        sel(adr(2'h3, 1'h0, 1'h1), 1'h1, "brown address");
        m.w(7);
        chk("pulling low", 8'h01, 8'(sda_oe));
        reset = 1'h1;
        m.w(2);
        chk("reset state", 8'h00, 8'(sda_oe | ready | write_busy));
        reset = 1'h0;
        m.stop();
        t_power();
        sel(adr(2'h3, 1'h0, 1'h0), 1'h1, "ack after restart");
        m.stop();
        $display("brown-out done");
    endtask : t_brown
    initial begin
        reset = 1'h1;
        strap_val = 2'h0;
        strap_en = 1'h0;
        wp_en = 1'h0;
        read_data = 8'h00;
        repeat (16) @(posedge clk_sys);
        #1;
        reset = 1'h0;
        t_power();
        t_select();
        t_write();
        t_read();
        t_brown();
        report_and_stop();
    end
    initial begin
        #2_000_000;
        fail("watchdog", 8'h00, 8'h01);
        report_and_stop();
    end
endmodule : serial_eeprom_bus_slave_tb_top
